// ===== design/status_sleep_regs.svh
// Purpose: constants for the status readout and deep sleep logic
// Assumes: opcodes and bit positions of the serial command set
// Notes: timing counts are in system clock cycles
`ifndef STATUS_SLEEP_REGS_SVH
`define STATUS_SLEEP_REGS_SVH
`define OPC_STATUS_READ 8'hD7
`define OPC_SLEEP_ENTER 8'hB9
`define OPC_SLEEP_WAKE 8'hAB
`define BYTE1_READY_BIT 7
`define BYTE1_COMPARE_BIT 6
`define BYTE1_DENSITY_HI 5
`define BYTE1_DENSITY_LO 2
`define BYTE1_PROTECT_BIT 1
`define BYTE1_PAGE_SIZE_BIT 0
`define BYTE2_READY_BIT 7
`define BYTE2_PROGRAM_FAIL_BIT 5
// Density code; value is arbitrary
`define DENSITY_CODE 4'h5
// Link clock divider: last count of each half period; a half period is four system clocks
`define LINK_HALF_DIV 4'h3
`endif

// ===== design/status_sleep_pkg.sv
// Purpose: shared types for the status readout and deep sleep logic
// Assumes: nothing beyond the header
// Notes: state codes are one-hot
package status_sleep_pkg;
  // Device command phase
  typedef enum logic [3:0] {
    PH_OPCODE = 4'h1,
    PH_STATUS = 4'h2,
    PH_IGNORE = 4'h4,
    PH_ARMED = 4'h8
  } phase_t;
  // Host sequencer states
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SHIFT = 4'h2,
    HS_GAP = 4'h4,
    HS_DONE = 4'h8
  } host_state_t;
endpackage

// ===== design/spi_link_if.sv
// Purpose: serial link between host and flash command logic
// Assumes: host makes the serial clock and chip select
// Notes: serial output plus enable; a released line reads high
`timescale 1ns/10ps
interface spi_link_if;
  logic sck; // Serial clock from host
  logic cs_n; // Chip select, active low
  logic si; // Host to device data
  logic so_out; // Device data out
  logic so_oe; // Device drives serial output
  // Documented device end
  modport device (input sck, input cs_n, input si, output so_out,
    output so_oe);
  // Host controller end
  modport host (output sck, output cs_n, output si, input so_out,
    input so_oe);
endinterface

// ===== design/sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: destination clock given as clk
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module sync2 #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg; // First stage, read only by q
  // Two stages toward the destination domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== design/flash_status_sleep.sv
// Purpose: device end; status word readout and deep sleep commands
// Assumes: serial clock is the only link clock; mode 0 sampling
// Notes: core inputs come from the system clock domain
//   deep sleep state lives in the chip-select domain
//
// How it works
// - status read answered anytime awake, two bytes
// - after D7h, drive status every clock
// - after second byte, restart with first
// - live status per byte, ready bit 7
// - chip select high ends readout, output off
// - byte one bit 6 is compare result
// - byte one bits 5:2 density code
// - byte one bit 1 protection enabled
// - byte one bit 0 page size 256
// - byte two reserved bits read zero
// - byte two bit 5 program failure
// - failure flag updated, not on abort
// - host polls until ready rises; spi_status_host sends one frame per start and leaves polling to software
// - standby when deselected, idle and awake
// - deep sleep ignores all but wake
// - B9h then deselect enters deep sleep
// - partial or misaligned entry aborted
// - power up lands in standby
// - entry ignored while operation busy
// - ABh then deselect wakes device
// - partial or misaligned wake aborted
`timescale 1ns/10ps
module flash_status_sleep (
  input wire logic clk_sys,
  input wire logic rst_n,
  spi_link_if.device link,
  input wire logic busy,
  input wire logic compare_mismatch,
  input wire logic protect_enabled,
  input wire logic page_size_256,
  input wire logic op_done,
  input wire logic op_failed,
  input wire logic op_aborted,
  output logic deep_sleep,
  output logic standby
);
`include "status_sleep_regs.svh"
  logic busy_l; // Busy seen in link domain
  logic cmp_l; // Compare result in link domain
  logic prot_l; // Protection in link domain
  logic page_l; // Page size in link domain
  logic fail_l; // Failure flag in link domain
  logic program_failure_flag_reg; // Sticky result of last operation
  logic sleep_reg; // Deep sleep state, link domain
  logic sleep_sys; // Sleep state seen by the core
  logic cs_sys; // Chip select seen by the core
  status_sleep_pkg::phase_t phase_reg; // Command phase
  logic [2:0] bit_cnt_reg; // Bit position in current byte
  logic [6:0] opc_reg; // Opcode bits so far
  logic byte_sel_reg; // Which status byte is shifting
  logic [7:0] shift_reg; // Status bits still to send
  logic [7:0] opc_full; // Opcode including current bit
  logic [7:0] byte1; // First status byte, live
  logic [7:0] byte2; // Second status byte, live
  logic armed_wake_reg; // Armed opcode was wake
  logic so_reg; // Output bit, falling edge
  logic standby_reg; // Standby level seen by the core
  // Failure flag: written on completion, kept on abort
  // An aborted run leaves the last verdict in place
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_failure_flag_reg <= 1'b0;
    end else if (op_done && !op_aborted) begin
      program_failure_flag_reg <= op_failed;
    end
  end
  // Core status into the link domain; levels only
  // These only move while sck runs; the opcode byte gives both
  // stages time to settle before the first status bit leaves
  sync2 u_s_busy (.clk(link.sck), .rst_n(rst_n), .d(busy), .q(busy_l));
  sync2 u_s_cmp (.clk(link.sck), .rst_n(rst_n), .d(compare_mismatch),
    .q(cmp_l));
  sync2 u_s_prot (.clk(link.sck), .rst_n(rst_n), .d(protect_enabled),
    .q(prot_l));
  sync2 u_s_page (.clk(link.sck), .rst_n(rst_n), .d(page_size_256),
    .q(page_l));
  sync2 u_s_fail (.clk(link.sck), .rst_n(rst_n),
    .d(program_failure_flag_reg), .q(fail_l));
  // Link state back into the core domain
  sync2 u_s_sleep (.clk(clk_sys), .rst_n(rst_n), .d(sleep_reg),
    .q(sleep_sys));
  // Chip select starts high so the core first sees a deselected link
  sync2 #(.INIT(1'b1)) u_s_cs (.clk(clk_sys), .rst_n(rst_n),
    .d(link.cs_n), .q(cs_sys));
  // Status bytes assembled fresh for every byte
  always_comb begin
    byte1 = 8'h00;
    byte1[`BYTE1_READY_BIT] = ~busy_l;
    byte1[`BYTE1_COMPARE_BIT] = cmp_l;
    byte1[`BYTE1_DENSITY_HI:`BYTE1_DENSITY_LO] = `DENSITY_CODE;
    byte1[`BYTE1_PROTECT_BIT] = prot_l;
    byte1[`BYTE1_PAGE_SIZE_BIT] = page_l;
    // Reserved bits of the second byte stay zero
    byte2 = 8'h00;
    byte2[`BYTE2_READY_BIT] = ~busy_l;
    byte2[`BYTE2_PROGRAM_FAIL_BIT] = fail_l;
  end
  // Opcode byte as it stands on the eighth rising edge
  assign opc_full = {opc_reg, link.si};
  // Bit counter; restarts each select since cs_n resets it
  // Three bits suffice: alignment only matters modulo 8
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= 3'h0;
      opc_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      opc_reg <= opc_full[6:0];
    end
  end
  // Command phase and status shifter
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      phase_reg <= status_sleep_pkg::PH_OPCODE;
      byte_sel_reg <= 1'b0;
      shift_reg <= 8'h00;
      armed_wake_reg <= 1'b0;
    end else begin
      case (phase_reg)
        status_sleep_pkg::PH_OPCODE: begin
          if (bit_cnt_reg == 3'h7) begin
            if (sleep_reg) begin
              // Only the wake opcode counts while asleep
              if (opc_full == `OPC_SLEEP_WAKE) begin
                phase_reg <= status_sleep_pkg::PH_ARMED;
                armed_wake_reg <= 1'b1;
              end else begin
                phase_reg <= status_sleep_pkg::PH_IGNORE;
              end
            end else if (opc_full == `OPC_STATUS_READ) begin
              // First byte loads now and leaves on the next fall
              phase_reg <= status_sleep_pkg::PH_STATUS;
              shift_reg <= byte1;
              byte_sel_reg <= 1'b0;
            end else if (opc_full == `OPC_SLEEP_ENTER && !busy_l) begin
              phase_reg <= status_sleep_pkg::PH_ARMED;
            end else begin
              // Unknown opcode, wake while awake, or entry while busy: sit out the frame
              phase_reg <= status_sleep_pkg::PH_IGNORE;
            end
          end
        end
        status_sleep_pkg::PH_STATUS: begin
          if (bit_cnt_reg == 3'h7) begin
            // Next byte loaded live; wraps after the second
            shift_reg <= byte_sel_reg ? byte1 : byte2;
            byte_sel_reg <= ~byte_sel_reg;
          end else begin
            // Otherwise move the next bit up to the output end
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        status_sleep_pkg::PH_ARMED: begin
          // Extra bits ignored; alignment judged at deselect
          phase_reg <= status_sleep_pkg::PH_ARMED;
        end
        default: begin
          // Ignore phase and any stray code wait for deselect
          phase_reg <= status_sleep_pkg::PH_IGNORE;
        end
      endcase
    end
  end
  // Sleep state changes only on a byte-aligned deselect
  // Chip select rise clocks this; phase and count still hold their
  // frame values here, as their own reset lands after this edge
  always_ff @(posedge link.cs_n or negedge rst_n) begin
    if (!rst_n) begin
      sleep_reg <= 1'b0;
    end else if (phase_reg == status_sleep_pkg::PH_ARMED &&
        bit_cnt_reg == 3'h0) begin
      sleep_reg <= ~armed_wake_reg;
    end else begin
      sleep_reg <= sleep_reg;
    end
  end
  // Output bit changes on falling clock, MSB first
  // Reset low so a fresh frame never starts on a stale bit
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= shift_reg[7];
    end
  end
  // Drive only during status phase; off when deselected
  // Never drives while asleep: no opcode reaches the status phase
  assign link.so_oe = !link.cs_n &&
    phase_reg == status_sleep_pkg::PH_STATUS;
  assign link.so_out = so_reg;
  assign deep_sleep = sleep_sys;
  // Standby: deselected, idle and awake; registered so the core
  // sees one clean level rather than raw and synchronised inputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      standby_reg <= 1'b0;
    end else begin
      standby_reg <= cs_sys && !busy && !sleep_sys;
    end
  end
  assign standby = standby_reg;
endmodule

// ===== design/spi_status_host.sv
// Purpose: host end; issues one command and captures status
// Assumes: serial clock divided down from clk_sys
// Notes: start is a one-cycle pulse; done pulses at the end
`timescale 1ns/10ps
module spi_status_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  spi_link_if.host link,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [3:0] read_bytes,
  input wire logic [2:0] extra_bits,
  output logic done,
  output logic [7:0] status_byte1,
  output logic [7:0] status_byte2
);
`include "status_sleep_regs.svh"
  status_sleep_pkg::host_state_t state_reg; // Sequencer state
  logic [3:0] div_reg; // Clock divider
  logic sck_reg; // Serial clock level
  logic cs_n_reg; // Chip select level
  logic [7:0] tx_reg; // Bits to send
  logic [6:0] bits_reg; // Bits left to clock
  logic [7:0] rx_reg; // Received bits
  logic [6:0] rx_cnt_reg; // Bits received
  logic so_sync; // Serial output synchronised
  logic tick; // Half period elapsed
  // A released line reads as its pull-up level, never a stale bit
  sync2 u_s_so (.clk(clk_sys), .rst_n(rst_n),
    .d(link.so_oe ? link.so_out : 1'b1), .q(so_sync));
  assign tick = div_reg == `LINK_HALF_DIV;
  // Free divider for the half period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
    end
  end
  // Frame sequencer; polling until ready rises is software's job
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= status_sleep_pkg::HS_IDLE;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      tx_reg <= 8'h00;
      bits_reg <= 7'h00;
      rx_reg <= 8'h00;
      rx_cnt_reg <= 7'h00;
      status_byte1 <= 8'h00;
      status_byte2 <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        status_sleep_pkg::HS_IDLE: begin
          if (start) begin
            state_reg <= status_sleep_pkg::HS_SHIFT;
            cs_n_reg <= 1'b0;
            tx_reg <= opcode;
            bits_reg <= 7'(8 + 8 * read_bytes + extra_bits);
            rx_cnt_reg <= 7'h00;
          end
        end
        status_sleep_pkg::HS_SHIFT: begin
          if (tick) begin
            if (!sck_reg) begin
              if (bits_reg == 7'h00) begin
                state_reg <= status_sleep_pkg::HS_GAP;
              end else begin
                sck_reg <= 1'b1;
              end
            end else begin
              // Falling edge: next bit out, sample reply bit
              sck_reg <= 1'b0;
              bits_reg <= bits_reg - 7'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              rx_cnt_reg <= rx_cnt_reg + 7'h1;
              if (rx_cnt_reg >= 7'h08) begin
                rx_reg <= {rx_reg[6:0], so_sync};
                if (rx_cnt_reg[2:0] == 3'h7) begin
                  if (rx_cnt_reg[3]) begin
                    status_byte1 <= {rx_reg[6:0], so_sync};
                  end else begin
                    status_byte2 <= {rx_reg[6:0], so_sync};
                  end
                end
              end
            end
          end
        end
        status_sleep_pkg::HS_GAP: begin
          if (tick) begin
            cs_n_reg <= 1'b1;
            state_reg <= status_sleep_pkg::HS_DONE;
          end
        end
        status_sleep_pkg::HS_DONE: begin
          done <= 1'b1;
          state_reg <= status_sleep_pkg::HS_IDLE;
        end
        default: begin
          state_reg <= status_sleep_pkg::HS_IDLE;
        end
      endcase
    end
  end
  assign link.sck = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.si = tx_reg[7];
endmodule

// ===== bench/status_sleep_assertions.sv
// Purpose: protocol checks on the serial status and sleep link
// Assumes: mode 0 framing; host divides clk_sys to make sck
// Notes: helper registers rebuild the bit position of each frame
`timescale 1ns/10ps
`include "status_sleep_regs.svh"
module status_sleep_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [4:0] bit_cnt_reg; // Bits in frame; wraps 31 to 16 to keep parity
  logic [7:0] op_reg; // Opcode seen on si
  logic [7:0] so_reg; // Last eight bits seen on so
  // Frame position, cleared while deselected
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 5'h00;
    end else begin
      bit_cnt_reg <= (bit_cnt_reg == 5'h1F) ? 5'h10 : bit_cnt_reg + 5'h01;
    end
  end
  // Opcode capture, first eight bits only
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      op_reg <= 8'h00;
    end else if (bit_cnt_reg < 5'h08) begin
      op_reg <= {op_reg[6:0], si};
    end
  end
  // Output capture, MSB first
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_reg <= 8'h00;
    end else begin
      so_reg <= {so_reg[6:0], so_out};
    end
  end
  chk_oe_off_deselect: assert property (
    @(posedge clk_sys) disable iff (!rst_n) cs_n |-> !so_oe)
    else $error("so driven while deselected");
  chk_oe_needs_opcode: assert property (
    @(posedge sck) disable iff (cs_n)
    so_oe |-> bit_cnt_reg >= 5'h08 && op_reg == `OPC_STATUS_READ)
    else $error("so driven without status opcode");
  chk_oe_held_frame: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    so_oe && !cs_n |=> so_oe || cs_n) else $error("so released mid frame");
  chk_so_steady_high: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    so_oe && sck && $past(sck) |-> $stable(so_out))
    else $error("so changed while sck high");
  // Whole bytes only: the capture holds one full byte every 8 edges
  chk_density_code: assert property (
    @(posedge sck) disable iff (cs_n)
    so_oe && bit_cnt_reg >= 5'h10 && !bit_cnt_reg[3] &&
    bit_cnt_reg[2:0] == 3'h0 |-> so_reg[5:2] == `DENSITY_CODE)
    else $error("density code wrong");
  chk_reserved_zero: assert property (
    @(posedge sck) disable iff (cs_n)
    so_oe && bit_cnt_reg >= 5'h10 && bit_cnt_reg[3] &&
    bit_cnt_reg[2:0] == 3'h0 |-> so_reg[6] == 1'b0 && so_reg[4:3] == 2'h0)
    else $error("reserved bit set");
  chk_sck_idle_low: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n && $past(cs_n) |-> !sck) else $error("sck moving outside frame");
  chk_sck_half_period: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(sck) |-> sck[*4] ##1 !sck) else $error("sck high time wrong");
endmodule

// ===== bench/status_readout_and_deep_sleep_tb.sv
// Purpose: host and device ends joined; status and sleep commands
// Assumes: done pulses once per frame; sleep state settles in 4 clocks
// Notes: driver queues notes, monitor compares on each done
`timescale 1ns/10ps
`include "status_sleep_regs.svh"
module status_readout_and_deep_sleep_tb;
  typedef struct {logic sk; logic [7:0] b1; logic [7:0] b2; logic sl;
    logic oe;} note_t;
  logic clk_sys, rst_n, busy, compare_mismatch, protect_enabled;
  logic page_size_256, op_done, op_failed, op_aborted, start, done;
  logic deep_sleep, standby, oe_seen, fail_model;
  logic [7:0] opcode, status_byte1, status_byte2;
  logic [3:0] read_bytes;
  logic [2:0] extra_bits;
  int fail_count, total_checks, seed;
  note_t notes[$]; // Expected results, oldest first
  spi_link_if i_link();
  flash_status_sleep i_flash_status_sleep(.clk_sys, .rst_n, .link(i_link),
    .busy, .compare_mismatch, .protect_enabled, .page_size_256, .op_done,
    .op_failed, .op_aborted, .deep_sleep, .standby);
  spi_status_host i_spi_status_host(.clk_sys, .rst_n, .link(i_link), .start,
    .opcode, .read_bytes, .extra_bits, .done, .status_byte1, .status_byte2);
  status_sleep_assertions i_chk(.clk_sys, .rst_n, .sck(i_link.sck),
    .cs_n(i_link.cs_n), .si(i_link.si), .so_out(i_link.so_out),
    .so_oe(i_link.so_oe));
  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Remember any so drive within a frame
  always @(posedge clk_sys) if (i_link.so_oe === 1'b1) oe_seen <= 1'b1;
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One erase/program completion pulse
  task automatic op_pulse(input logic f, input logic ab);
    @(posedge clk_sys);
    #1;
    op_done = 1'b1;
    op_failed = f;
    op_aborted = ab;
    if (!ab) fail_model = f; // Aborted runs leave the flag alone
    @(posedge clk_sys);
    #1;
    op_done = 1'b0;
  endtask
  // One frame; sk selects a sleep-state note over a status note
  task automatic cmd(input logic [7:0] op, input logic [3:0] nb,
    input logic [2:0] xb, input logic sk, input logic sl, input logic oe);
    note_t n;
    n.sk = sk;
    n.sl = sl;
    n.oe = oe;
    n.b1 = {~busy, compare_mismatch, `DENSITY_CODE, protect_enabled,
      page_size_256};
    n.b2 = {~busy, 1'b0, fail_model, 5'h00};
    @(posedge clk_sys);
    #1;
    opcode = op;
    read_bytes = nb;
    extra_bits = xb;
    oe_seen = 1'b0;
    start = 1'b1;
    notes.push_back(n);
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    // Bounded wait; the watchdog covers a lost done
    repeat (3000) begin
      @(posedge clk_sys);
      if (done === 1'b1) break;
    end
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  // Monitor: one note per done
  initial begin
    note_t e;
    forever begin
      @(posedge clk_sys);
      if (done === 1'b1) begin
        e = notes.pop_front();
        repeat (4) @(posedge clk_sys);
        total_checks++;
        if (e.sk) begin
          if (deep_sleep !== e.sl ||
              standby !== (!e.sl && !busy)) begin
            fail_count++;
            $display("Error at %0t: sleep state wrong", $time);
          end
          if (oe_seen !== e.oe) begin
            fail_count++;
            $display("Error at %0t: so drive wrong", $time);
          end
        end else begin
          if (status_byte1 !== e.b1) begin
            fail_count++;
            $display("Error at %0t: first byte wrong", $time);
          end
          if (status_byte2 !== e.b2) begin
            fail_count++;
            $display("Error at %0t: second byte wrong", $time);
          end
        end
      end
    end
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    $display("Error at %0t: timeout", $time);
    final_report();
  end
  initial begin
    {rst_n, busy, compare_mismatch, protect_enabled, op_done} = 5'h00;
    {op_failed, op_aborted, start, oe_seen, fail_model} = 5'h00;
    page_size_256 = 1'b1;
    opcode = 8'h00;
    read_bytes = 4'h0;
    extra_bits = 3'h0;
    seed = $urandom(32'hF2DA1A0A);
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // Random live status, busy included, with failure flag updates
    for (int i = 0; i < 6; i++) begin
      op_pulse(1'($urandom), 1'b0);
      if (i[0]) op_pulse(~fail_model, 1'b1);
      {busy, compare_mismatch, protect_enabled, page_size_256} = 4'($urandom);
      cmd(`OPC_STATUS_READ, 4'(2 + 2 * $urandom_range(2)), 3'h0, 1'b0, 1'b0,
        1'b0);
    end
    busy = 1'b0;
    $display("test 1 finished");
    cmd(`OPC_STATUS_READ, 4'h1, 3'h3, 1'b1, 1'b0, 1'b1);
    cmd(`OPC_SLEEP_ENTER, 4'h0, 3'h5, 1'b1, 1'b0, 1'b0);
    busy = 1'b1;
    cmd(`OPC_SLEEP_ENTER, 4'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    busy = 1'b0;
    $display("test 2 finished");
    cmd(`OPC_SLEEP_ENTER, 4'h1, 3'h0, 1'b1, 1'b1, 1'b0);
    cmd(`OPC_STATUS_READ, 4'h2, 3'h0, 1'b1, 1'b1, 1'b0);
    cmd(`OPC_SLEEP_WAKE, 4'h0, 3'h3, 1'b1, 1'b1, 1'b0);
    cmd(`OPC_SLEEP_WAKE, 4'h1, 3'h0, 1'b1, 1'b0, 1'b0);
    cmd(`OPC_STATUS_READ, 4'h3, 3'h0, 1'b0, 1'b0, 1'b0);
    $display("test 3 finished");
    // Power cycle while asleep: back in standby, failure flag cleared
    cmd(`OPC_SLEEP_ENTER, 4'h0, 3'h0, 1'b1, 1'b1, 1'b0);
    rst_n = 1'b0;
    fail_model = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    cmd(`OPC_STATUS_READ, 4'h1, 3'h0, 1'b1, 1'b0, 1'b1);
    cmd(`OPC_STATUS_READ, 4'h2, 3'h0, 1'b0, 1'b0, 1'b0);
    $display("test 4 finished");
    final_report();
  end
endmodule
